// ### shared/vrsf_map.vh
// Constants for the voice recorder serial frame slave.
// Operation
// (R1) Input bits sampled on rising clock, LSB first
// (R2) Frame carries two to seven input bytes
// (R3) First byte is opcode, rest are arguments
// (R4) Command bit 4 enables the LED
// (R5) Frame length fixed per command type
// (R6) Ranged commands carry 11-bit start, end rows
// (R7) Data commands carry a 12-bit data word
// (R8) Host zeroes don't-care bits; device ignores them
// (R9) Rows 0x000-0x00F effects, 0x010 general start
// (R10) Output bits driven on falling clock, LSB first
// (R11) First two output bytes hold status word
// (R12) Status bits: error, full, power, END_OF_MESSAGE_FLAG, done
// (R13) Error bit reports previous command acceptance
// (R14) Read commands return data in bytes three, four
// (R15) Bytes five to seven repeat status word
// (R16) Idle: select high, clock high, input low
// (R17) Select low frames the whole transaction
// (R18) Interrupt low after operation until cleared
// (R19) Short frame is discarded without effect
`ifndef VRSF_MAP_VH
`define VRSF_MAP_VH

// ****************************************************************
// Command byte
// ****************************************************************
`define VRSF_OP_MASK 8'hEF
`define VRSF_LED_BIT 4
`define VRSF_OP_CLEAR_INT 8'h04
`define VRSF_OP_READ_STATUS 8'h05
`define VRSF_OP_READ_PLAY_PTR 8'h06
`define VRSF_OP_READ_REC_PTR 8'h08
`define VRSF_OP_READ_IDENTITY 8'h09
`define VRSF_OP_READ_APC 8'h44
`define VRSF_OP_WRITE_APC 8'h45
`define VRSF_OP_RANGED_PLAY 8'h80
`define VRSF_OP_RANGED_REC 8'h81
`define VRSF_OP_RANGED_ERASE 8'h82

// ****************************************************************
// Frame lengths in bytes; full frame length in bits
// ****************************************************************
`define VRSF_LEN_SHORT 3'h2
`define VRSF_LEN_THREE 3'h3
`define VRSF_LEN_FOUR 3'h4
`define VRSF_LEN_RANGED 3'h7
`define VRSF_FRAME_BITS 6'h38

// ****************************************************************
// Status word layout
// ****************************************************************
`define VRSF_ST_CMD_ERR 0
`define VRSF_ST_FULL 1
`define VRSF_ST_POWER 2
`define VRSF_ST_EOM 3
`define VRSF_ST_DONE 4
`define VRSF_ST_ROW_LSB 5

// ****************************************************************
// Row map
// ****************************************************************
`define VRSF_ROW_EFFECT_LAST 11'h00F
`define VRSF_ROW_FIRST_GENERAL 11'h010

`endif

// ### hdl/vrsf_sync.v
// Two-stage pin synchroniser with edge detection.
`timescale 1ns/1ps
module vrsf_sync #(
	parameter W = 3,
	parameter [W-1:0] IDLE = {W{1'b0}}
) (
	// Clock and reset.
	input wire clk,
	input wire reset,
	// Asynchronous pins.
	input wire [W-1:0] din,
	// Synchronised view.
	output wire [W-1:0] level,
	output wire [W-1:0] rise,
	output wire [W-1:0] fall
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;
	reg [W-1:0] prev_q;

	// Only the second stage feeds the edge logic, never the first.
	always @(posedge clk) begin
		if (reset) begin
			meta_q <= IDLE;
			sync_q <= IDLE;
			prev_q <= IDLE;
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise = sync_q & ~prev_q;
	assign fall = ~sync_q & prev_q;
endmodule // vrsf_sync

// ### hdl/vrsf_frame.v
// Serial frame slave: shifts commands in and status and data out.
`timescale 1ns/1ps
`include "vrsf_map.vh"
module vrsf_frame (
	// Clock and reset.
	input wire clk,
	input wire reset,
	// Serial pins from the host.
	input wire sclk,
	input wire ssN,
	input wire mosi,
	// Serial pins to the host.
	output reg miso,
	output wire misoOe,
	output wire intN,
	output wire led,
	// Decoded command towards the device core.
	output reg cmdValid,
	output reg [7:0] cmdOpcode,
	output reg [11:0] cmdData,
	output reg [10:0] startRow,
	output reg [10:0] endRow,
	output reg ledEnable,
	output reg startIsEffect,
	output reg [1:0] effectSlot,
	// Early opcode so the core can prepare read data.
	output reg frameOpValid,
	output reg [7:0] frameOpcode,
	input wire [15:0] readData,
	// Core state.
	input wire opDone,
	input wire opBusy,
	input wire statCmdErr,
	input wire statFull,
	input wire statPowerUp,
	input wire statEom,
	input wire [10:0] curRow
);
	// ****************************************************************
	// Pin synchronisation
	// ****************************************************************
	wire [2:0] pinLevel;
	wire [2:0] pinRise;
	wire [2:0] pinFall;

	// Idle levels: select high, clock high, input low. (R16)
	vrsf_sync #(
		.W(3),
		.IDLE(3'h6)
	) uSync (
		.clk(clk),
		.reset(reset),
		.din({ssN, sclk, mosi}),
		.level(pinLevel),
		.rise(pinRise),
		.fall(pinFall)
	);

	wire mosiS = pinLevel[0];
	wire sclkRise = pinRise[1];
	wire sclkFall = pinFall[1];
	wire ssActive = ~pinLevel[2];
	wire ssStart = pinFall[2];
	wire ssEnd = pinRise[2];

	// ****************************************************************
	// Command decode helpers
	// ****************************************************************
	function [2:0] cmdLen;
		input [7:0] op;
		begin
			case (op & `VRSF_OP_MASK) // R5
				`VRSF_OP_READ_STATUS,
				`VRSF_OP_READ_IDENTITY,
				`VRSF_OP_WRITE_APC: cmdLen = `VRSF_LEN_THREE;
				`VRSF_OP_READ_APC,
				`VRSF_OP_READ_PLAY_PTR,
				`VRSF_OP_READ_REC_PTR: cmdLen = `VRSF_LEN_FOUR;
				`VRSF_OP_RANGED_PLAY,
				`VRSF_OP_RANGED_REC,
				`VRSF_OP_RANGED_ERASE: cmdLen = `VRSF_LEN_RANGED;
				default: cmdLen = `VRSF_LEN_SHORT;
			endcase
		end
	endfunction

	function isReadCmd;
		input [7:0] op;
		begin
			case (op & `VRSF_OP_MASK) // R14
				`VRSF_OP_READ_STATUS,
				`VRSF_OP_READ_IDENTITY,
				`VRSF_OP_READ_APC,
				`VRSF_OP_READ_PLAY_PTR,
				`VRSF_OP_READ_REC_PTR: isReadCmd = 1'b1;
				default: isReadCmd = 1'b0;
			endcase
		end
	endfunction

	// Output stream: status, status-or-data, status, low status.
	function txBit;
		input [5:0] idx;
		input [15:0] stat;
		input [15:0] rsp;
		input useRsp;
		reg [2:0] byteNo;
		reg [15:0] word;
		begin
			byteNo = idx[5:3];
			if (useRsp && (byteNo == 3'h2 || byteNo == 3'h3)) begin
				word = rsp; // R14
			end else begin
				word = stat; // R11 R15
			end
			txBit = word[{byteNo[0], idx[2:0]}]; // R10
		end
	endfunction

	// ****************************************************************
	// Receive path
	// ****************************************************************
	reg [55:0] rx_q;
	reg [5:0] rxIdx_q;
	reg [5:0] txIdx_q;
	reg [15:0] stat_q;
	reg [15:0] rsp_q;
	reg rspValid_q;
	reg int_q;
	reg ledEn_q;

	wire [7:0] rxOp = rx_q[7:0];
	wire opSeen = (rxIdx_q >= 6'h08);
	wire frameFull = (rxIdx_q == `VRSF_FRAME_BITS);
	wire [5:0] needBits = {cmdLen(rxOp), 3'h0};
	// Bits past the seventh byte are dropped rather than wrapping the index.
	wire accept = ssEnd && opSeen && (rxIdx_q >= needBits); // R2 R19
	wire isClear = ((rxOp & `VRSF_OP_MASK) == `VRSF_OP_CLEAR_INT);

	always @(posedge clk) begin
		if (reset) begin
			rx_q <= 56'h0;
			rxIdx_q <= 6'h0;
		end else if (ssStart) begin
			rx_q <= 56'h0;
			rxIdx_q <= 6'h0; // R17
		end else if (ssActive && sclkRise && !frameFull) begin
			rx_q[rxIdx_q] <= mosiS; // R1
			rxIdx_q <= rxIdx_q + 6'h1;
		end
	end

	// The core gets one byte time between the opcode and the data latch.
	always @(posedge clk) begin
		if (reset) begin
			frameOpValid <= 1'b0;
			frameOpcode <= 8'h00;
			rsp_q <= 16'h0000;
			rspValid_q <= 1'b0;
		end else begin
			frameOpValid <= 1'b0;
			if (ssStart) begin
				rspValid_q <= 1'b0;
			end else if (ssActive && sclkRise && rxIdx_q == 6'h07) begin
				frameOpValid <= 1'b1; // R3
				frameOpcode <= {mosiS, rx_q[6:0]};
			end else if (ssActive && sclkRise && rxIdx_q == 6'h0F) begin
				rsp_q <= readData;
				rspValid_q <= isReadCmd(rxOp); // R14
			end
		end
	end

	// ****************************************************************
	// Transmit path
	// ****************************************************************
	// Snapshot at select fall so the frame reports the previous command.
	always @(posedge clk) begin
		if (reset) begin
			stat_q <= 16'h0000;
			txIdx_q <= 6'h0;
			miso <= 1'b0;
		end else if (ssStart) begin
			stat_q[`VRSF_ST_CMD_ERR] <= statCmdErr; // R12 R13
			stat_q[`VRSF_ST_FULL] <= statFull;
			stat_q[`VRSF_ST_POWER] <= statPowerUp;
			stat_q[`VRSF_ST_EOM] <= statEom;
			stat_q[`VRSF_ST_DONE] <= int_q;
			stat_q[15:`VRSF_ST_ROW_LSB] <= curRow; // R11
			txIdx_q <= 6'h0;
			miso <= 1'b0;
		end else if (ssActive && sclkFall && txIdx_q != `VRSF_FRAME_BITS) begin
			miso <= txBit(txIdx_q, stat_q, rsp_q, rspValid_q); // R10
			txIdx_q <= txIdx_q + 6'h1;
		end
	end

	assign misoOe = ssActive;

	// ****************************************************************
	// Command hand-off
	// ****************************************************************
	// Argument fields take only the defined bits; the rest is ignored.
	always @(posedge clk) begin
		if (reset) begin
			cmdValid <= 1'b0;
			cmdOpcode <= 8'h00;
			cmdData <= 12'h000;
			startRow <= 11'h000;
			endRow <= 11'h000;
			ledEnable <= 1'b0;
			startIsEffect <= 1'b0;
			effectSlot <= 2'h0;
		end else begin
			cmdValid <= 1'b0;
			if (accept) begin
				cmdValid <= 1'b1; // R3
				cmdOpcode <= rxOp;
				cmdData <= {rx_q[19:16], rx_q[15:8]}; // R7 R8
				startRow <= {rx_q[26:24], rx_q[23:16]}; // R6 R8
				endRow <= {rx_q[42:40], rx_q[39:32]}; // R6
				ledEnable <= rxOp[`VRSF_LED_BIT]; // R4
				startIsEffect <= ({rx_q[26:24], rx_q[23:16]} <= `VRSF_ROW_EFFECT_LAST); // R9
				effectSlot <= rx_q[19:18]; // R9
			end
		end
	end

	// ****************************************************************
	// Interrupt and LED
	// ****************************************************************
	// A completion in the same cycle as a clear keeps the interrupt set.
	always @(posedge clk) begin
		if (reset) begin
			int_q <= 1'b0;
			ledEn_q <= 1'b0;
		end else begin
			if (opDone) begin
				int_q <= 1'b1; // R18
			end else if (accept && isClear) begin
				int_q <= 1'b0; // R18
			end
			if (accept) begin
				ledEn_q <= rxOp[`VRSF_LED_BIT]; // R4
			end
		end
	end

	assign intN = ~int_q;
	assign led = ledEn_q & opBusy; // R4
endmodule // vrsf_frame

// ### verif/vrsf_host.sv
// Serial master model that frames bytes into the slave.
`timescale 1ns/1ps
module vrsf_host (
	// Serial pins.
	output logic sclk = 1'b1,
	output logic ssN = 1'b1,
	output logic mosi = 1'b0,
	input wire miso
);
	int hp = 80;
	task automatic xfer(input logic [55:0] tx, input int nb, output logic [55:0] rx);
		rx = 56'h0;
		ssN = 1'b0;
		#(hp);
		for (int i = 0; i < nb * 8; i++) begin
			sclk = 1'b0;
			mosi = tx[i];
			#(hp);
			rx[i] = miso;
			sclk = 1'b1;
			#(hp);
		end
		mosi = 1'b0;
		ssN = 1'b1;
		#(hp);
	endtask
endmodule // vrsf_host

// ### verif/vrsf_frame_assertions.sv
// Assertions on the serial frame slave ports.
`timescale 1ns/1ps
module vrsf_frame_assertions (
	// Clock and reset.
	input wire clk,
	input wire reset,
	// Watched ports.
	input wire sclk,
	input wire ssN,
	input wire miso,
	input wire misoOe,
	input wire intN,
	input wire led,
	input wire cmdValid,
	input wire [7:0] cmdOpcode,
	input wire ledEnable,
	input wire frameOpValid,
	input wire opDone,
	input wire opBusy
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence selIdle;
		ssN [*3];
	endsequence
	AST_OE: assert property (selIdle |-> !misoOe) else $error("oe");
	AST_ACC: assert property (cmdValid |-> ssN && $past(ssN)) else $error("acc");
	AST_LEDB: assert property (cmdValid |-> ledEnable == cmdOpcode[4]) else $error("ledb");
	AST_LED: assert property (led == (ledEnable && opBusy)) else $error("led");
	AST_INTS: assert property (opDone |=> !intN) else $error("ints");
	AST_INTC: assert property ($rose(intN) && !$past(reset) |->
		(cmdValid || $past(cmdValid)) && (cmdOpcode & 8'hEF) == 8'h04) else $error("intc");
	AST_MISO: assert property ($changed(miso) && misoOe && $past(misoOe, 2) |->
		!$past(sclk, 3) || !$past(sclk, 4)) else $error("miso");
	AST_FOP: assert property (frameOpValid |-> misoOe ##1 !frameOpValid) else $error("fop");
endmodule // vrsf_frame_assertions
bind vrsf_frame vrsf_frame_assertions chk_i (.clk(clk), .reset(reset), .sclk(sclk),
	.ssN(ssN), .miso(miso), .misoOe(misoOe), .intN(intN), .led(led), .cmdValid(cmdValid),
	.cmdOpcode(cmdOpcode), .ledEnable(ledEnable), .frameOpValid(frameOpValid),
	.opDone(opDone), .opBusy(opBusy));

// ### verif/tb_voice_recorder_spi_frame.sv
// Self-checking bench for the serial frame slave.
`timescale 1ns/1ps
module tb_voice_recorder_spi_frame;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic opDone, opBusy, statCmdErr, statFull, statPowerUp, statEom, intExp;
	logic [10:0] curRow;
	logic [15:0] readData, st;
	logic [31:0] seed = 32'h25D9;
	logic [63:0] r;
	logic [55:0] tx, rx, m;
	logic [7:0] op;
	// Opcode table with frame lengths and read flags; clearing comes last.
	logic [87:0] ops = 88'h0482818045440908060501;
	logic [43:0] lens = 44'h27773434432;
	logic [10:0] rds = 11'h03E;
	int nMismatch = 0;
	int totalChecks = 0;
	int nv = 0;
	int n, nv0;
	wire sclk, ssN, mosi, miso, intN, cmdValid, ledEnable, startIsEffect;
	wire misoOe, misoPin, led;
	wire [7:0] cmdOpcode, frameOpcode;
	wire [11:0] cmdData;
	wire [10:0] startRow, endRow;
	wire [1:0] effectSlot;
	// A released output line shows the inverse of the held bit, so a late read fails.
	assign misoPin = misoOe ? miso : ~miso;
	vrsf_host vrsf_host_inst (.sclk(sclk), .ssN(ssN), .mosi(mosi), .miso(misoPin));
	vrsf_frame vrsf_frame_inst (.clk(clk), .reset(reset), .sclk(sclk), .ssN(ssN),
		.mosi(mosi), .miso(miso), .misoOe(misoOe), .intN(intN), .led(led),
		.cmdValid(cmdValid),
		.cmdOpcode(cmdOpcode), .cmdData(cmdData), .startRow(startRow), .endRow(endRow),
		.ledEnable(ledEnable), .startIsEffect(startIsEffect), .effectSlot(effectSlot),
		.frameOpValid(), .frameOpcode(frameOpcode), .readData(readData), .opDone(opDone),
		.opBusy(opBusy), .statCmdErr(statCmdErr), .statFull(statFull),
		.statPowerUp(statPowerUp), .statEom(statEom), .curRow(curRow));
	always #5 clk = ~clk;
	always @(posedge clk) if (cmdValid === 1'b1) nv <= nv + 1;
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [55:0] expw(logic [15:0] s, logic [15:0] d, logic rd);
		return {s[7:0], s, rd ? d : s, s};
	endfunction
	task automatic chk(input logic [55:0] g, input logic [55:0] e);
		totalChecks++;
		if (g !== e) begin
			nMismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic endSim();
		$display("checks %0d mismatches %0d", totalChecks, nMismatch);
		if (nMismatch == 0 && totalChecks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		{opDone, intExp} = 2'h0;
		{statCmdErr, statFull, statPowerUp, statEom, opBusy, curRow, readData} = 32'h0;
		repeat (16) @(posedge clk);
		#1 reset = 1'b0;
		repeat (4) @(posedge clk);
		#1 opDone = 1'b1;
		@(posedge clk);
		#1 opDone = 1'b0;
		intExp = 1'b1;
		chk(intN, 1'b0);
		for (int i = 0; i < 11; i++) begin
			@(posedge clk);
			r = {rnd(), rnd()};
			#1 {statCmdErr, statFull, statPowerUp, statEom, opBusy, curRow, readData} = rnd();
			op = ops[8 * i +: 8] | {r[63], 4'h0};
			tx = {r[55:8], op};
			if (r[62]) tx[26:16] = {6'h00, r[60:56]};
			st = {curRow, intExp, statEom, statPowerUp, statFull, statCmdErr};
			n = lens[4 * i +: 4];
			nv0 = nv;
			// A frame one byte short, sent only when the full frame is over two bytes, must issue no command.
			if (n > 2) vrsf_host_inst.xfer(tx, n - 1, rx);
			chk(nv - nv0, 0);
			vrsf_host_inst.xfer(tx, n, rx);
			m = ~(56'hFFFFFFFFFFFFFF << (8 * n));
			chk(rx & m, expw(st, readData, rds[i]) & m);
			chk({nv - nv0, cmdOpcode, ledEnable}, {32'h1, op, op[4]});
			chk({frameOpcode, led}, {op, op[4] & opBusy});
			if (n == 7) chk({startRow, endRow, startIsEffect, effectSlot},
				{tx[26:16], tx[42:32], (tx[26:16] <= 11'h00F), tx[19:18]});
			if ((op & 8'hEF) == 8'h45) chk(cmdData, tx[19:8]);
			if ((op & 8'hEF) == 8'h04) intExp = 1'b0;
			$display("test %0d op %h done", i, op);
		end
		chk(intN, 1'b1);
		endSim();
	end
	// The frames take about 105 us; 300 us, nearly three times that, is a hang.
	initial begin
		#300000;
		nMismatch++;
		endSim();
	end
endmodule // tb_voice_recorder_spi_frame
